// ===== verilog/pfpg_defs.svh
`ifndef PFPG_DEFS_SVH
`define PFPG_DEFS_SVH

// register byte offsets
`define PFPG_OFS_SETTING 4'h0
`define PFPG_OFS_STATUS 4'h4
`define PFPG_OFS_IRQ_MASK 4'h8
`define PFPG_OFS_CTRL 4'hC

// setting register fields
`define PFPG_BIT_OPEN 7
`define PFPG_BIT_RNV 6
`define PFPG_BIT_HDIS 5
`define PFPG_HS_MSB 4
`define PFPG_HS_LSB 3
`define PFPG_BIT_LDIS 2
`define PFPG_LS_MSB 1
`define PFPG_LS_LSB 0

// full protection value after a double fault
`define PFPG_FULL_PROT 8'h7F
`define PFPG_SETTING_RST 8'h7F

// status / mask bits
`define PFPG_ST_VIOL 0
`define PFPG_ST_LOADERR 1

// flash map
`define PFPG_CFG_ADDR 23'h7F_FF0C
`define PFPG_HIGH_END 23'h7F_FFFF
`define PFPG_LOW_BASE 23'h7F_8000
`define PFPG_HIGH_2K 23'h00_0800
`define PFPG_LOW_1K 23'h00_0400

`endif

// ===== verilog/pfpg_pkg.sv
package pfpg_pkg;
    typedef enum logic [1:0] {
        PFPG_OP_PROGRAM,
        PFPG_OP_SECTOR_ERASE,
        PFPG_OP_BLOCK_ERASE,
        PFPG_OP_OTHER
    } pfpg_op_t;

    typedef struct packed {
        logic valid;
        pfpg_op_t op;
        logic [22:0] addr;
        logic [22:0] block_base;
        logic [22:0] block_last;
    } pfpg_req_t;

    typedef struct packed {
        logic valid;
        logic granted;
        logic violation;
    } pfpg_resp_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [3:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } pfpg_avm_req_t;
endpackage

// ===== verilog/pfpg_range_check.sv
`timescale 1ns/1ps
`include "pfpg_defs.svh"

module pfpg_range_check
    import pfpg_pkg::*;
(
    input wire logic [7:0] setting,
    input wire logic [22:0] lo_addr,
    input wire logic [22:0] hi_addr,
    output logic hit
);
    logic [22:0] high_start;
    logic [22:0] low_last;
    logic in_high;
    logic in_low;
    logic open_bit;
    logic hdis;
    logic ldis;

    always_comb begin
        open_bit = setting[`PFPG_BIT_OPEN];
        hdis = setting[`PFPG_BIT_HDIS];
        ldis = setting[`PFPG_BIT_LDIS];
        high_start = `PFPG_HIGH_END - ((`PFPG_HIGH_2K << setting[`PFPG_HS_MSB:`PFPG_HS_LSB])
            - 23'h00_0001);
        low_last = `PFPG_LOW_BASE + ((`PFPG_LOW_1K << setting[`PFPG_LS_MSB:`PFPG_LS_LSB])
            - 23'h00_0001);
        // span overlaps range
        in_high = (hi_addr >= high_start) && (lo_addr <= `PFPG_HIGH_END);
        in_low = (hi_addr >= `PFPG_LOW_BASE) && (lo_addr <= low_last);
        if (open_bit) begin
            hit = (!hdis && in_high) || (!ldis && in_low);
        end else begin
            // ranges unprotected; a span crossing out of the high window, or past the end of the low one, counts
            hit = !(((!hdis && in_high && lo_addr >= high_start)
                || (!ldis && in_low && hi_addr <= low_last)));
        end
    end
endmodule // pfpg_range_check

// ===== verilog/pfpg_guard.sv
`timescale 1ns/1ps
`include "pfpg_defs.svh"

// Notes on behaviour
// - at reset, load setting from config byte at flash 0x7F_FF0C
// - double fault on that read: open bit cleared, all else set
// - program/erase into protected area refused, violation flag set
// - block erase refused if any sector of that block protected, except with open=0 a block ending in the unprotected low range
// - setting: open 7, rnv 6, hdis 5, hs 4-3, ldis 2, ls 1-0
// - open=1: disable bits choose protected high/low ranges
// - open=0: disable bits choose unprotected ranges, else all protected
// - high size 00..11 means 2,4,8,16 KB ending at top of flash
// - low size 00..11 means 1,2,4,8 KB from lower base
// - high size writable only while high disable currently set
// - low size writable only while low disable currently set
// - disallowed scenario transitions are ignored per fixed table
// - setting reads return the scenario in force
// - violation flag cleared by writing one, zero has no effect

module pfpg_guard
    import pfpg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic cfg_rd_req,
    output logic [22:0] cfg_rd_addr,
    input wire logic cfg_rd_valid,
    input wire logic [7:0] cfg_rd_data,
    input wire logic cfg_rd_dbl_fault,
    input wire pfpg_req_t cmd_req,
    output pfpg_resp_t cmd_resp,
    output logic load_done,
    output logic irq
);
    typedef enum logic [1:0] {
        PFPG_LD_REQ,
        PFPG_LD_WAIT,
        PFPG_LD_DONE
    } pfpg_ld_state_t;

    pfpg_ld_state_t ld_state;
    logic [7:0] program_flash_protection_setting;
    logic [1:0] status;
    logic [1:0] irq_mask;
    logic ack;
    logic wr_hit;
    logic rd_hit;
    logic [7:0] wdata;
    logic [7:0] next_setting;
    logic [2:0] cur_scn;
    logic [2:0] new_scn;
    logic scn_ok;
    logic hit_addr;
    logic hit_block;
    logic is_block;
    logic refuse;
    logic viol_set;
    logic loaderr_set;

    // one wait cycle per access keeps the answer registered
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end
    assign avs_waitrequest = (avs_read || avs_write) && !ack;
    assign wr_hit = avs_write && ack;
    assign rd_hit = avs_read && !ack;
    assign wdata = avs_writedata[7:0];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ld_state <= PFPG_LD_REQ;
        end else begin
            case (ld_state)
                PFPG_LD_REQ: ld_state <= PFPG_LD_WAIT;
                PFPG_LD_WAIT: begin
                    if (cfg_rd_valid) begin
                        ld_state <= PFPG_LD_DONE;
                    end
                end
                PFPG_LD_DONE: ld_state <= PFPG_LD_DONE;
                default: ld_state <= PFPG_LD_REQ;
            endcase
        end
    end
    assign cfg_rd_req = (ld_state == PFPG_LD_REQ);
    assign cfg_rd_addr = `PFPG_CFG_ADDR;
    assign load_done = (ld_state == PFPG_LD_DONE);

    assign cur_scn = {program_flash_protection_setting[`PFPG_BIT_OPEN],
        program_flash_protection_setting[`PFPG_BIT_HDIS],
        program_flash_protection_setting[`PFPG_BIT_LDIS]};
    assign new_scn = {wdata[`PFPG_BIT_OPEN], wdata[`PFPG_BIT_HDIS], wdata[`PFPG_BIT_LDIS]};

    always_comb begin
        case (cur_scn)
            3'd0: scn_ok = (new_scn <= 3'd3);
            3'd1: scn_ok = (new_scn == 3'd1) || (new_scn == 3'd3);
            3'd2: scn_ok = (new_scn == 3'd2) || (new_scn == 3'd3);
            3'd3: scn_ok = (new_scn == 3'd3);
            3'd4: scn_ok = (new_scn == 3'd3) || (new_scn == 3'd4);
            3'd5: scn_ok = (new_scn >= 3'd2) && (new_scn <= 3'd5);
            3'd6: scn_ok = (new_scn == 3'd1) || (new_scn == 3'd3) || (new_scn == 3'd4)
                || (new_scn == 3'd6);
            3'd7: scn_ok = 1'b1;
            default: scn_ok = 1'b0;
        endcase
    end

    always_comb begin
        next_setting = program_flash_protection_setting;
        next_setting[`PFPG_BIT_OPEN] = wdata[`PFPG_BIT_OPEN];
        next_setting[`PFPG_BIT_RNV] = wdata[`PFPG_BIT_RNV];
        next_setting[`PFPG_BIT_HDIS] = wdata[`PFPG_BIT_HDIS];
        next_setting[`PFPG_BIT_LDIS] = wdata[`PFPG_BIT_LDIS];
        if (program_flash_protection_setting[`PFPG_BIT_HDIS]) begin
            next_setting[`PFPG_HS_MSB:`PFPG_HS_LSB] = wdata[`PFPG_HS_MSB:`PFPG_HS_LSB];
        end
        if (program_flash_protection_setting[`PFPG_BIT_LDIS]) begin
            next_setting[`PFPG_LS_MSB:`PFPG_LS_LSB] = wdata[`PFPG_LS_MSB:`PFPG_LS_LSB];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            program_flash_protection_setting <= `PFPG_SETTING_RST;
        end else if (ld_state == PFPG_LD_WAIT && cfg_rd_valid) begin
            if (cfg_rd_dbl_fault) begin
                program_flash_protection_setting <= `PFPG_FULL_PROT;
            end else begin
                program_flash_protection_setting <= cfg_rd_data;
            end
        end else if (wr_hit && avs_address == `PFPG_OFS_SETTING && avs_byteenable[0]
            && load_done && scn_ok) begin
            program_flash_protection_setting <= next_setting;
        end
    end

    assign is_block = (cmd_req.op == PFPG_OP_BLOCK_ERASE);

    pfpg_range_check u_addr_check (
        .setting(program_flash_protection_setting),
        .lo_addr(cmd_req.addr),
        .hi_addr(cmd_req.addr),
        .hit(hit_addr)
    );

    pfpg_range_check u_block_check (
        .setting(program_flash_protection_setting),
        .lo_addr(cmd_req.block_base),
        .hi_addr(cmd_req.block_last),
        .hit(hit_block)
    );

    assign refuse = cmd_req.valid && (cmd_req.op != PFPG_OP_OTHER)
        && (!load_done || (is_block ? hit_block : hit_addr));
    assign viol_set = refuse;
    assign loaderr_set = (ld_state == PFPG_LD_WAIT) && cfg_rd_valid && cfg_rd_dbl_fault;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cmd_resp <= '0;
        end else begin
            cmd_resp.valid <= cmd_req.valid;
            cmd_resp.granted <= cmd_req.valid && !refuse;
            cmd_resp.violation <= refuse;
        end
    end

    // sticky flags, set wins over write-one clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status <= 2'b00;
        end else begin
            if (viol_set) begin
                status[`PFPG_ST_VIOL] <= 1'b1;
            end else if (wr_hit && avs_address == `PFPG_OFS_STATUS && avs_byteenable[0]
                && avs_writedata[`PFPG_ST_VIOL]) begin
                status[`PFPG_ST_VIOL] <= 1'b0;
            end
            if (loaderr_set) begin
                status[`PFPG_ST_LOADERR] <= 1'b1;
            end else if (wr_hit && avs_address == `PFPG_OFS_STATUS && avs_byteenable[0]
                && avs_writedata[`PFPG_ST_LOADERR]) begin
                status[`PFPG_ST_LOADERR] <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            irq_mask <= 2'b00;
        end else if (wr_hit && avs_address == `PFPG_OFS_IRQ_MASK && avs_byteenable[0]) begin
            irq_mask <= avs_writedata[1:0];
        end
    end

    assign irq = |(status & irq_mask);

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (rd_hit) begin
            case (avs_address)
                `PFPG_OFS_SETTING: avs_readdata <= {24'h00_0000, program_flash_protection_setting};
                `PFPG_OFS_STATUS: avs_readdata <= {30'h0000_0000, status};
                `PFPG_OFS_IRQ_MASK: avs_readdata <= {30'h0000_0000, irq_mask};
                `PFPG_OFS_CTRL: avs_readdata <= {31'h0000_0000, load_done};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // pfpg_guard

// ===== dv/pfpg_guard_props.sv
`timescale 1ns/1ps
module pfpg_guard_props
    import pfpg_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic cfg_rd_req,
    input wire logic [22:0] cfg_rd_addr,
    input wire logic cfg_rd_valid,
    input wire pfpg_req_t cmd_req,
    input wire pfpg_resp_t cmd_resp,
    input wire logic load_done
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_cfg_req_start: assert property ($fell(rst) |-> cfg_rd_req)
        else $error("config read not requested after reset");
    a_cfg_addr_fixed: assert property (cfg_rd_req |-> cfg_rd_addr == 23'h7F_FF0C)
        else $error("config read at wrong address");
    // a stale answer while the request still stands is ignored by the design
    a_load_follows: assert property (cfg_rd_valid && !cfg_rd_req && !load_done |=> load_done)
        else $error("load not done after config byte");
    a_load_holds: assert property (load_done |=> load_done)
        else $error("load done dropped");
    a_resp_next: assert property (cmd_req.valid |=> cmd_resp.valid)
        else $error("no response to command");
    a_resp_one_kind: assert property (cmd_resp.valid
        |-> cmd_resp.granted ^ cmd_resp.violation)
        else $error("response neither or both granted and refused");
    a_no_stray_resp: assert property (cmd_resp.valid |-> $past(cmd_req.valid))
        else $error("response without command");
    a_other_granted: assert property (cmd_req.valid && cmd_req.op == PFPG_OP_OTHER && load_done
        |=> cmd_resp.granted)
        else $error("non altering command refused");
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest)
        else $error("bus answer late");
endmodule // pfpg_guard_props

bind pfpg_guard pfpg_guard_props pfpg_guard_props_i (.ref_clk, .rst, .avs_read, .avs_write,
    .avs_waitrequest, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_valid, .cmd_req, .cmd_resp, .load_done);

// ===== dv/pfpg_flash_model.sv
`timescale 1ns/1ps
module pfpg_flash_model (
    input wire logic ref_clk,
    input wire logic cfg_rd_req,
    input wire logic [22:0] cfg_rd_addr,
    input wire logic [7:0] cfg_byte,
    input wire logic fault,
    input wire logic [3:0] lat,
    output logic cfg_rd_valid,
    output logic [7:0] cfg_rd_data,
    output logic cfg_rd_dbl_fault
);
    logic [4:0] cnt = 5'h1F;
    always_ff @(posedge ref_clk) begin
        if (cfg_rd_req && cfg_rd_addr == 23'h7F_FF0C) cnt <= {1'b0, lat};
        else if (cnt != 5'h1F) cnt <= cnt - 5'h01;
    end
    assign cfg_rd_valid = (cnt == 5'h00);
    assign cfg_rd_dbl_fault = cfg_rd_valid && fault;
    // inverted outside the answer, so a stale byte never passes
    assign cfg_rd_data = cfg_rd_valid ? cfg_byte : ~cfg_byte;
endmodule // pfpg_flash_model

// ===== dv/test_pfpg_guard.sv
`timescale 1ns/1ps
module test_pfpg_guard;
    import pfpg_pkg::*;
    typedef struct packed {
        logic [7:0] cfg, wr, ex;
        logic [1:0] op;
        logic [22:0] ad;
        logic vi;
    } pfpg_row_t;
    logic ref_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, fault = 1'b0;
    logic [3:0] avs_address = '0, avs_byteenable = '0, lat = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic avs_waitrequest, cfg_rd_req, cfg_rd_valid, cfg_rd_dbl_fault, load_done, irq;
    logic [22:0] cfg_rd_addr;
    logic [7:0] cfg_rd_data, cfg_byte = '0;
    pfpg_req_t cmd_req = '0;
    pfpg_resp_t cmd_resp;
    int err_count = 0, samples_checked = 0, cyc = 0;
    pfpg_row_t rows [12] = '{
        '{8'hFF, 8'hDC, 8'hDC, 2'h0, 23'h7F_C000, 1'b1},
        '{8'h9C, 8'hBF, 8'h9C, 2'h0, 23'h7F_BFFF, 1'b0},
        '{8'h9C, 8'h84, 8'h9C, 2'h1, 23'h7F_C000, 1'b1},
        '{8'hA0, 8'hA3, 8'hA0, 2'h0, 23'h7F_83FF, 1'b1},
        '{8'hA0, 8'hA0, 8'hA0, 2'h0, 23'h7F_8400, 1'b0},
        '{8'h7F, 8'hFF, 8'h7F, 2'h1, 23'h7F_8000, 1'b1},
        '{8'h18, 8'h1C, 8'h1C, 2'h0, 23'h7F_C000, 1'b0},
        '{8'h18, 8'h18, 8'h18, 2'h0, 23'h7F_BFFF, 1'b1},
        '{8'hDC, 8'hDC, 8'hDC, 2'h2, 23'h7F_8000, 1'b1},
        '{8'hFF, 8'hFF, 8'hFF, 2'h2, 23'h7F_8000, 1'b0},
        '{8'h83, 8'h80, 8'h83, 2'h0, 23'h7F_9FFF, 1'b1},
        '{8'h7F, 8'h7F, 8'h7F, 2'h3, 23'h7F_8000, 1'b0}};
    always #12.5 ref_clk = ~ref_clk;
    pfpg_guard pfpg_guard_i (.ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_valid,
        .cfg_rd_data, .cfg_rd_dbl_fault, .cmd_req, .cmd_resp, .load_done, .irq);
    pfpg_flash_model pfpg_flash_model_i (.ref_clk, .cfg_rd_req, .cfg_rd_addr, .cfg_byte, .fault,
        .lat, .cfg_rd_valid, .cfg_rd_data, .cfg_rd_dbl_fault);
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask
    task bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= 4'h1;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 8'h00);
        chk(q, exp);
    endtask
    task rst_load(input logic [7:0] c, input logic f);
        cfg_byte <= c;
        fault <= f;
        rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        do @(negedge ref_clk); while (load_done !== 1'b1);
        @(posedge ref_clk);
    endtask
    task cmd(input logic [1:0] op, input logic [22:0] ad, input logic vi);
        cmd_req <= {1'b1, op, ad, 23'h7F_8000, 23'h7F_FFFF};
        @(posedge ref_clk);
        cmd_req <= '0;
        @(negedge ref_clk);
        chk({29'h0000_0000, cmd_resp}, {29'h0000_0000, 1'b1, !vi, vi});
        @(posedge ref_clk);
    endtask
    initial begin
        foreach (rows[i]) begin
            lat <= i[3:0];
            rst_load(rows[i].cfg, 1'b0);
            // reserved bit of every accepted byte taken from the write
            bus(1'b1, 4'h0, rows[i].wr);
            rd(4'h0, {24'h00_0000, rows[i].ex});
            cmd(rows[i].op, rows[i].ad, rows[i].vi);
        end
        // faulty config read, then sticky flags and interrupt
        rst_load(8'h00, 1'b1);
        rd(4'h0, 32'h0000_007F);
        rd(4'h4, 32'h0000_0002);
        cmd(2'h0, 23'h7F_C000, 1'b1);
        rd(4'h4, 32'h0000_0003);
        bus(1'b1, 4'h4, 8'h02);
        bus(1'b1, 4'h4, 8'h00);
        rd(4'h4, 32'h0000_0001);
        chk(irq, 1'b0);
        bus(1'b1, 4'h8, 8'h01);
        chk(irq, 1'b1);
        bus(1'b1, 4'h4, 8'h01);
        rd(4'h4, 32'h0000_0000);
        chk(irq, 1'b0);
        rd(4'h2, 32'h0000_0000);
        rd(4'hC, 32'h0000_0001);
        test_done;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            test_done;
        end
    end
    task test_done;
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
endmodule // test_pfpg_guard
